// >>> logic/rasq_regs.svh
// Purpose: Register offsets, field positions and timing counts for the remainder ADC sequencer.
// Assumes: 125 MHz reference clock; register port with 8-bit byte address, 32-bit data.
// Notes:   Definitions only.
// What this block does
// (R1) Diagnostics select routes the system diagnostic line to the converter input.
// (R2) DAC-high select routes the divided DAC high diagnostic voltage to the input.
// (R3) Heater-monitor select routes summed amplifier and reference heater voltages to input.
// (R4) Amplifier-output select routes the null amplifier output to the converter input.
// (R5) A conversion starts only on a falling edge of the trigger line.
// (R6) Once triggered, five 6-bit nibbles are produced with no host help.
// (R7) Each conversion is five passes of autozero, compare, then remainder store.
// (R8) Idle sits in autozero: ladder code zero, comparator tied to store offset.
// (R9) Compare uses external input on pass one, stored remainder on later passes.
// (R10) Compare steps ladder bits by comparator polarity, resolving six bits per pass.
// (R11) Remainder store runs a gain-16 difference amplifier onto one remainder capacitor.
// (R12) A stored remainder is the compare input of the following pass.
// (R13) After five passes the conversion-done interrupt is raised.
// (R14) Host reads the data port five times, one nibble per pass.
// (R15) Pass results combine into a signed value of about 22 bits.
// (R16) Remainder capacitors alternate between passes so reading never meets writing.
// (R17) Done holds until five reads, then back to autozero idle, or until a new trigger, which starts a fresh conversion.
`ifndef RASQ_REGS_SVH
`define RASQ_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define RASQ_ADDR_CTRL    8'h00
`define RASQ_ADDR_STATUS  8'h04
`define RASQ_ADDR_MASK    8'h08
`define RASQ_ADDR_NIBBLE  8'h0c
`define RASQ_ADDR_RESULT  8'h10

// ==========================================================
// Field positions and codes
`define RASQ_ST_DONE      0
`define RASQ_ST_OVR       1
`define RASQ_ST_BUSY      2
`define RASQ_SEL_NONE     3'h0
`define RASQ_SEL_DIAG     3'h1
`define RASQ_SEL_DACHI    3'h2
`define RASQ_SEL_HEATER   3'h3
`define RASQ_SEL_AMPOUT   3'h4
`define RASQ_CTRL_RST     3'h0
`define RASQ_MASK_RST     2'h0

// ==========================================================
// Conversion arithmetic
`define RASQ_NIB_MSB      3'h5
`define RASQ_NIB_TRIAL    6'h20
`define RASQ_NIB_OFS      23'h000020
`define RASQ_GAIN_SHIFT   4
`define RASQ_LAST_PASS    3'h4

// ==========================================================
// Timing: times in ns, cycle counts derived (least times round up)
`define RASQ_CLK_MHZ      125
`define RASQ_AZ_NS        2000
`define RASQ_BIT_NS       400
`define RASQ_STORE_NS     2000
`define RASQ_AZ_CYC       12'((`RASQ_AZ_NS * `RASQ_CLK_MHZ + 999) / 1000)
`define RASQ_BIT_CYC      12'((`RASQ_BIT_NS * `RASQ_CLK_MHZ + 999) / 1000)
`define RASQ_STORE_CYC    12'((`RASQ_STORE_NS * `RASQ_CLK_MHZ + 999) / 1000)

`endif

// >>> logic/rasq_pkg.sv
// Purpose: Types shared by the remainder ADC sequencer.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes:   Constants live in rasq_regs.svh.
`default_nettype none
package rasq_pkg;
	// Sequencer phases
	typedef enum logic [2:0] {
		RASQ_IDLE  = 3'b000,
		RASQ_AZ    = 3'b001,
		RASQ_CMP   = 3'b010,
		RASQ_STORE = 3'b011,
		RASQ_DONE  = 3'b100
	} rasq_state_t;

	// Analog input selects, at most one high
	typedef struct packed {
		logic diag_line_select;
		logic dac_high_diag_select;
		logic heater_monitor_select;
		logic amp_out_select;
	} rasq_sel_t;

	// Comparator/amplifier switch controls
	typedef struct packed {
		logic       autozero;
		logic       cmp_ext;
		logic [1:0] cmp_rem;
		logic [1:0] store_rem;
		logic       diff_amp;
	} rasq_sw_t;
endpackage : rasq_pkg
`default_nettype wire

// >>> logic/rasq_seq.sv
// Purpose: Recirculating-remainder ADC sequencer with input select and register port.
// Assumes: All inputs synchronous to i_ref_clk; comparator polarity high means input above ladder.
// Notes:   Ladder code is offset binary; result register holds the signed combination.
`include "rasq_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module rasq_seq
	import rasq_pkg::*;
#(
	parameter int PASSES = 5
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	input  wire logic        i_conv_trig,
	input  wire logic        i_cmp_pol,
	output rasq_sel_t        o_sel,
	output rasq_sw_t         o_sw,
	output logic      [5:0]  o_ladder_code,
	output logic             o_irq
);

	// ==========================================================
	// Declarations
	rasq_state_t state_q;
	logic [11:0] cnt_q;
	logic [2:0]  bit_q;
	logic [2:0]  pass_q;
	logic [2:0]  rd_idx_q;
	logic [5:0]  ladder_q;
	logic [5:0]  ladder_res;
	logic [5:0]  nib_q [PASSES];
	logic [22:0] acc_q;
	logic        trig_q;
	logic        trig_fall;
	logic [2:0]  ctrl_q;
	logic [1:0]  mask_q;
	logic        done_q;
	logic        ovr_q;
	logic        busy;
	logic        nib_pop;
	logic        last_pop;
	logic        pass_end;
	logic        conv_end;
	logic        restart;
	rasq_sw_t    sw_q;
	rasq_sel_t   sel_q;
	logic [31:0] rdata_q;
	logic        irq_q;

	// ==========================================================
	// Trigger edge and event decode
	// Inputs are synchronous, so one flop is enough for the edge
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			trig_q <= 1'b1;
		end else begin
			trig_q <= i_conv_trig;
		end
	end

	assign trig_fall = trig_q & ~i_conv_trig;                                   // R5
	assign busy      = (state_q == RASQ_AZ) || (state_q == RASQ_CMP) || (state_q == RASQ_STORE);
	assign nib_pop   = i_rd && (i_addr == `RASQ_ADDR_NIBBLE) && (state_q == RASQ_DONE);
	assign last_pop  = nib_pop && (rd_idx_q == 3'(PASSES - 1));                 // R17
	assign pass_end  = (state_q == RASQ_STORE) && (cnt_q == 12'h000);
	assign conv_end  = pass_end && (pass_q == 3'(PASSES - 1));
	// A trigger while results wait discards them and starts afresh
	assign restart   = trig_fall && (state_q == RASQ_DONE);                     // R17

	// Successive approximation step: keep or drop the trial bit, try the next
	always_comb begin
		ladder_res = ladder_q;
		ladder_res[bit_q] = i_cmp_pol;                                           // R10
		if (bit_q != 3'h0) begin
			ladder_res[bit_q - 3'h1] = 1'b1;
		end
	end

	// ==========================================================
	// Sequencer
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_q  <= RASQ_IDLE;
			cnt_q    <= 12'h000;
			bit_q    <= 3'h0;
			pass_q   <= 3'h0;
			rd_idx_q <= 3'h0;
			ladder_q <= 6'h00;
		end else begin
			case (state_q)
				RASQ_IDLE: begin
					ladder_q <= 6'h00;                                           // R8
					if (trig_fall) begin                                         // R5
						state_q <= RASQ_AZ;
						pass_q  <= 3'h0;
						cnt_q   <= `RASQ_AZ_CYC - 12'h001;
					end
				end
				RASQ_AZ: begin
					// Ladder at zero while the offset settles on the autozero cap
					ladder_q <= 6'h00;
					if (cnt_q == 12'h000) begin                                  // R7
						state_q  <= RASQ_CMP;
						bit_q    <= `RASQ_NIB_MSB;
						ladder_q <= `RASQ_NIB_TRIAL;
						cnt_q    <= `RASQ_BIT_CYC - 12'h001;
					end else begin
						cnt_q <= cnt_q - 12'h001;
					end
				end
				RASQ_CMP: begin
					if (cnt_q == 12'h000) begin
						ladder_q <= ladder_res;                                  // R10
						if (bit_q == 3'h0) begin
							state_q <= RASQ_STORE;                               // R7
							cnt_q   <= `RASQ_STORE_CYC - 12'h001;
						end else begin
							bit_q <= bit_q - 3'h1;
							cnt_q <= `RASQ_BIT_CYC - 12'h001;
						end
					end else begin
						cnt_q <= cnt_q - 12'h001;
					end
				end
				RASQ_STORE: begin
					// Ladder holds the nibble so the amplifier sees input minus ladder
					if (cnt_q == 12'h000) begin
						if (conv_end) begin
							state_q  <= RASQ_DONE;                               // R6
							rd_idx_q <= 3'h0;
							ladder_q <= 6'h00;
						end else begin
							state_q <= RASQ_AZ;                                  // R7
							pass_q  <= pass_q + 3'h1;
							cnt_q   <= `RASQ_AZ_CYC - 12'h001;
						end
					end else begin
						cnt_q <= cnt_q - 12'h001;
					end
				end
				RASQ_DONE: begin
					ladder_q <= 6'h00;                                           // R8
					if (restart) begin
						state_q <= RASQ_AZ;
						pass_q  <= 3'h0;
						cnt_q   <= `RASQ_AZ_CYC - 12'h001;
					end else if (last_pop) begin
						state_q <= RASQ_IDLE;                                    // R17
					end else if (nib_pop) begin
						rd_idx_q <= rd_idx_q + 3'h1;                             // R14
					end
				end
				default: begin
					state_q <= RASQ_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Nibble store and signed combination
	// Each pass carries gain 16, so nibbles overlap by two bits; that
	// redundancy absorbs comparator error from an earlier pass.
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			acc_q <= 23'h000000;
			for (int i = 0; i < PASSES; i++) begin
				nib_q[i] <= 6'h00;
			end
		end else if (state_q == RASQ_IDLE && trig_fall || restart) begin
			acc_q <= 23'h000000;
		end else if (pass_end) begin
			nib_q[pass_q] <= ladder_q;                                           // R6
			acc_q <= (acc_q << `RASQ_GAIN_SHIFT) + {17'h00000, ladder_q} - `RASQ_NIB_OFS; // R15
		end
	end

	// ==========================================================
	// Analog switch controls, registered from the phase
	// Caps alternate by pass parity: pass n stores on cap n%2 and
	// compares against cap (n-1)%2, so no cap is read and written at once.
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sw_q <= '0;
		end else begin
			sw_q          <= '0;
			sw_q.autozero <= (state_q == RASQ_IDLE) || (state_q == RASQ_AZ) || (state_q == RASQ_DONE); // R8
			if (state_q == RASQ_CMP) begin
				if (pass_q == 3'h0) begin
					sw_q.cmp_ext <= 1'b1;                                        // R9
				end else if (pass_q[0]) begin
					sw_q.cmp_rem <= 2'b01;                                       // R12
				end else begin
					sw_q.cmp_rem <= 2'b10;                                       // R12
				end
			end
			if (state_q == RASQ_STORE) begin
				sw_q.diff_amp  <= 1'b1;                                          // R11
				sw_q.store_rem <= pass_q[0] ? 2'b10 : 2'b01;                     // R16
			end
		end
	end

	// ==========================================================
	// Input select lines decoded from the control register
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sel_q <= '0;
		end else begin
			sel_q.diag_line_select      <= (ctrl_q == `RASQ_SEL_DIAG);           // R1
			sel_q.dac_high_diag_select  <= (ctrl_q == `RASQ_SEL_DACHI);          // R2
			sel_q.heater_monitor_select <= (ctrl_q == `RASQ_SEL_HEATER);         // R3
			sel_q.amp_out_select        <= (ctrl_q == `RASQ_SEL_AMPOUT);         // R4
		end
	end

	// ==========================================================
	// Writable registers
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ctrl_q <= `RASQ_CTRL_RST;
			mask_q <= `RASQ_MASK_RST;
		end else if (i_wr) begin
			if (i_addr == `RASQ_ADDR_CTRL) begin
				ctrl_q <= i_wdata[2:0];
			end
			if (i_addr == `RASQ_ADDR_MASK) begin
				mask_q <= i_wdata[1:0];
			end
		end
	end

	// Sticky status: hardware set wins over a write-one clear
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			done_q <= 1'b0;
			ovr_q  <= 1'b0;
		end else begin
			if (conv_end) begin
				done_q <= 1'b1;                                                  // R13
			end else if (last_pop || restart ||
				(i_wr && i_addr == `RASQ_ADDR_STATUS && i_wdata[`RASQ_ST_DONE])) begin
				done_q <= 1'b0;                                                  // R17
			end
			// Triggers during a conversion are ignored but recorded
			if (trig_fall && busy) begin
				ovr_q <= 1'b1;
			end else if (i_wr && i_addr == `RASQ_ADDR_STATUS && i_wdata[`RASQ_ST_OVR]) begin
				ovr_q <= 1'b0;
			end
		end
	end

	// Level interrupt, one cycle behind the status
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |({ovr_q, done_q} & mask_q);                                // R13
		end
	end

	// ==========================================================
	// Read data, valid the cycle after the strobe; unmapped reads zero
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rdata_q <= 32'h00000000;
		end else if (i_rd) begin
			case (i_addr)
				`RASQ_ADDR_CTRL:   rdata_q <= {29'h0, ctrl_q};
				`RASQ_ADDR_STATUS: rdata_q <= {29'h0, busy, ovr_q, done_q};
				`RASQ_ADDR_MASK:   rdata_q <= {30'h0, mask_q};
				`RASQ_ADDR_NIBBLE: rdata_q <= {26'h0, nib_q[rd_idx_q]};          // R14
				`RASQ_ADDR_RESULT: rdata_q <= {{9{acc_q[22]}}, acc_q};           // R15
				default:           rdata_q <= 32'h00000000;
			endcase
		end else begin
			rdata_q <= 32'h00000000;
		end
	end

	assign o_rdata       = rdata_q;
	assign o_sel         = sel_q;
	assign o_sw          = sw_q;
	assign o_ladder_code = ladder_q;
	assign o_irq         = irq_q;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_az_end;
		state_q == RASQ_AZ && cnt_q == 12'h000;
	endsequence
	sequence s_cmp_end;
		state_q == RASQ_CMP && cnt_q == 12'h000 && bit_q == 3'h0;
	endsequence
	sequence s_pass_end;
		state_q == RASQ_STORE && cnt_q == 12'h000;
	endsequence

	a_trig_starts: assert property (state_q == RASQ_IDLE && trig_fall |=> state_q == RASQ_AZ) // R5
		else $error("falling trigger did not start a conversion");
	a_no_edge_idle: assert property (state_q == RASQ_IDLE && !trig_fall |=> state_q == RASQ_IDLE) // R5
		else $error("conversion started without a falling trigger");
	a_idle_autozero: assert property (state_q == RASQ_IDLE |-> ladder_q == 6'h00 ##1 sw_q.autozero) // R8
		else $error("idle left autozero or ladder not zero");
	a_phase_order: assert property (s_az_end |=> state_q == RASQ_CMP ##0 ladder_q == `RASQ_NIB_TRIAL) // R7
		else $error("autozero not followed by compare");
	a_cmp_to_store: assert property (s_cmp_end |=> state_q == RASQ_STORE ##1 sw_q.diff_amp) // R11
		else $error("compare not followed by remainder store");
	a_bit_resolve: assert property (state_q == RASQ_CMP && cnt_q == 12'h000 // R10
		|=> ladder_q[$past(bit_q)] == $past(i_cmp_pol))
		else $error("ladder bit does not follow comparator polarity");
	a_cmp_source: assert property (state_q == RASQ_CMP |=> // R9
		(pass_q == 3'h0) ? (sw_q.cmp_ext && sw_q.cmp_rem == 2'b00) : (!sw_q.cmp_ext && sw_q.cmp_rem != 2'b00))
		else $error("wrong compare source for the pass");
	// Store cap of a later pass must differ from the cap its compare has just read
	a_cap_alternate: assert property (pass_q != 3'h0 ##0 s_cmp_end |=> // R16
		##1 (sw_q.store_rem != $past(sw_q.cmp_rem) && sw_q.store_rem != 2'b00))
		else $error("remainder cap written while in use");
	a_done_irq: assert property (conv_end && mask_q[`RASQ_ST_DONE] |=> done_q ##1 o_irq) // R13
		else $error("conversion end did not raise the interrupt");
	a_done_holds: assert property (done_q && !last_pop && !restart && !i_wr |=> done_q) // R17
		else $error("done flag dropped early");
	a_select_onehot: assert property ($onehot0(o_sel)) // R1
		else $error("more than one input select active");
	a_pass_step: assert property (s_pass_end |=> // R7
		(state_q == RASQ_AZ && pass_q == $past(pass_q) + 3'h1) || state_q == RASQ_DONE)
		else $error("pass did not advance after remainder store");
	a_store_hold: assert property (state_q == RASQ_STORE && cnt_q != 12'h000 |=> $stable(ladder_q)) // R11
		else $error("ladder moved during remainder store");
	a_busy_overrun: assert property (trig_fall && busy |=> ovr_q) // R5
		else $error("trigger during conversion not recorded");
	a_last_read_idle: assert property (last_pop && !restart |=> state_q == RASQ_IDLE && !done_q) // R17
		else $error("fifth nibble read did not return to idle");
	a_diag_select: assert property (i_wr && i_addr == `RASQ_ADDR_CTRL && i_wdata[2:0] == `RASQ_SEL_DIAG // R1
		|=> ##1 o_sel.diag_line_select)
		else $error("diagnostics select did not follow the control write");
endmodule : rasq_seq
`default_nettype wire

// >>> bench/rasq_cmp_model.sv
// Purpose: Comparator front-end model that answers the sequencer's ladder trials.
// Assumes: Pass count restarts on each trigger fall; one target nibble per pass.
// Notes:   Input above ladder gives polarity 1, so a binary search lands on the target.
`timescale 1ns/1ns
`default_nettype none
module rasq_cmp_model
	import rasq_pkg::*;
#(
	parameter logic [29:0] TARGETS = 30'h0
) (
	input  wire logic       i_ref_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_conv_trig,
	input  wire rasq_sw_t   i_sw,
	input  wire logic [5:0] i_ladder_code,
	output logic            o_cmp_pol
);
	logic [2:0] pass_q;
	logic       trig_q;
	logic       amp_q;
	// ==========================================================
	// Pass tracking: a new pass begins when the store phase ends
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pass_q <= 3'h0;
			trig_q <= 1'b1;
			amp_q  <= 1'b0;
		end else begin
			trig_q <= i_conv_trig;
			amp_q  <= i_sw.diff_amp;
			if (trig_q && !i_conv_trig) begin
				pass_q <= 3'h0;
			end else if (amp_q && !i_sw.diff_amp && pass_q != 3'h4) begin
				pass_q <= pass_q + 3'h1;
			end
		end
	end
	// Comparator: stays combinational so each trial is judged as the ladder settles
	assign o_cmp_pol = TARGETS[29 - 6 * pass_q -: 6] >= i_ladder_code;
endmodule : rasq_cmp_model
`default_nettype wire

// >>> bench/rasq_seq_tb.sv
// Purpose: Self-checking bench for the remainder ADC sequencer.
// Assumes: Register port strobes one cycle long; read data in the next cycle only.
// Notes:   Conversions take about 4000 cycles, so only three are run.
`include "rasq_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module rasq_seq_tb;
	import rasq_pkg::*;
	localparam logic [29:0] NIBS = {6'h3f, 6'h00, 6'h21, 6'h15, 6'h2a};
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  addr    = 8'h00;
	logic [31:0] wdata   = 32'h0;
	logic        wr      = 1'b0;
	logic        rd      = 1'b0;
	logic        trig    = 1'b1;
	logic [31:0] rdata;
	logic        pol;
	logic        irq;
	logic [5:0]  ladder;
	rasq_sel_t   sel;
	rasq_sw_t    sw;
	logic [1:0]  cur_rem = 2'h0;
	logic [1:0]  last_st = 2'h0;
	logic [1:0]  prev_rem = 2'h0;
	logic        prev_amp = 1'b0;
	int          mismatches = 0;
	int          tests_run = 0;
	int          acc;
	int          n;
	always #4 ref_clk = ~ref_clk;
	rasq_seq uut (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_conv_trig(trig), .i_cmp_pol(pol), .o_sel(sel), .o_sw(sw),
		.o_ladder_code(ladder), .o_irq(irq));
	rasq_cmp_model #(.TARGETS(NIBS)) cmp (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_conv_trig(trig),
		.i_sw(sw), .i_ladder_code(ladder), .o_cmp_pol(pol));
	// ==========================================================
	// Bus and compare tasks
	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask : wr_reg
	task rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd_reg(a, d);
		check(d, exp);
	endtask : rd_chk
	// Trigger pulse: low for two cycles so the falling edge is clean
	task trig_fall;
		@(posedge ref_clk);
		trig <= 1'b0;
		@(posedge ref_clk);
		@(posedge ref_clk);
		trig <= 1'b1;
	endtask : trig_fall
	// Bounded wait on the interrupt; a hang ends the run
	task wait_irq;
		n = 0;
		while (irq !== 1'b1) begin
			@(posedge ref_clk);
			#1 n++;
			if (n > 4200) begin
				mismatches++;
				$display("[ERR] %0t interrupt never came", $time);
				end_of_test();
			end
		end
	endtask : wait_irq
	task end_of_test;
		$display("Counts: %0d compares, %0d mismatches", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test
	// ==========================================================
	// Switch monitor: remainders chain pass to pass and never collide
	always @(posedge ref_clk) begin
		if (!sys_rst) begin
			prev_rem <= sw.cmp_rem;
			prev_amp <= sw.diff_amp;
			if (sw.cmp_ext || sw.cmp_rem != 2'h0) begin
				cur_rem <= sw.cmp_rem;
			end
			if (sw.cmp_rem != 2'h0 && prev_rem == 2'h0) begin
				check({sw.cmp_ext, sw.cmp_rem}, {1'b0, last_st});
			end
			if (sw.diff_amp && !prev_amp) begin
				check(sw.store_rem == cur_rem, 1'b0);
				last_st <= sw.store_rem;
			end
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1 check({sw.autozero, ladder, irq}, {1'b1, 6'h00, 1'b0});
		rd_chk(`RASQ_ADDR_STATUS, 32'h0);
		rd_chk(`RASQ_ADDR_MASK, 32'h0);
		rd_chk(`RASQ_ADDR_CTRL, 32'h0);
		rd_chk(8'h14, 32'h0);
		$display("Test reset values done");
		for (int c = 1; c <= 5; c++) begin
			wr_reg(`RASQ_ADDR_CTRL, c);
			repeat (2) @(posedge ref_clk);
			#1 check(sel, (c == 5) ? 4'h0 : 4'h8 >> (c - 1));
		end
		$display("Test input selects done");
		wr_reg(`RASQ_ADDR_MASK, 32'h1);
		trig_fall();
		rd_chk(`RASQ_ADDR_STATUS, 32'h4);
		trig_fall();
		rd_chk(`RASQ_ADDR_STATUS, 32'h6);
		check(irq, 1'b0);
		wait_irq();
		check(n > 3980 && n < 4010, 1'b1);
		rd_chk(`RASQ_ADDR_STATUS, 32'h3);
		acc = 0;
		for (int k = 0; k < 5; k++) begin
			acc = acc * 16 + int'(NIBS[29 - 6 * k -: 6]) - 32;
		end
		rd_chk(`RASQ_ADDR_RESULT, acc);
		for (int k = 0; k < 5; k++) begin
			rd_chk(`RASQ_ADDR_NIBBLE, NIBS[29 - 6 * k -: 6]);
		end
		repeat (3) @(posedge ref_clk);
		#1 check({irq, sw.autozero, ladder}, {1'b0, 1'b1, 6'h00});
		rd_chk(`RASQ_ADDR_STATUS, 32'h2);
		wr_reg(`RASQ_ADDR_STATUS, 32'h2);
		rd_chk(`RASQ_ADDR_STATUS, 32'h0);
		$display("Test conversion done");
		wr_reg(`RASQ_ADDR_MASK, 32'h0);
		trig_fall();
		repeat (4010) @(posedge ref_clk);
		#1 check(irq, 1'b0);
		rd_chk(`RASQ_ADDR_STATUS, 32'h1);
		trig_fall();
		rd_chk(`RASQ_ADDR_STATUS, 32'h4);
		repeat (4010) @(posedge ref_clk);
		wr_reg(`RASQ_ADDR_MASK, 32'h1);
		wait_irq();
		wr_reg(`RASQ_ADDR_STATUS, 32'h1);
		repeat (2) @(posedge ref_clk);
		#1 check(irq, 1'b0);
		rd_chk(`RASQ_ADDR_STATUS, 32'h0);
		$display("Test masked and restart done");
		end_of_test();
	end
endmodule : rasq_seq_tb
`default_nettype wire
